// [vectored_interrupt_controller_tb_top.sv]
// Self-checking bench for the vectored interrupt controller.
// Assumes vic_pkg, vic_params.svh and vic_core_model are compiled first.
`timescale 1ns/100ps
`include "vic_params.svh"
module vectored_interrupt_controller_tb_top;
  import vic_pkg::*;
  logic        ref_clk, sys_rst, fast_request, normal_request;
  logic [15:0] ext_irq;
  logic [47:0] chip_irq;
  vic_addr_t   awaddr, araddr;
  vic_word_t   wdata, rdata, rd_v;
  vic_strb_t   wstrb;
  vic_resp_t   bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  fast_taken, normal_taken;
  int          bad_count, compares;

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  vic_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .ext_irq(ext_irq), .chip_irq(chip_irq),
    .fast_request(fast_request), .normal_request(normal_request),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  vic_core_model core_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .fast_request(fast_request),
    .normal_request(normal_request), .fast_taken(fast_taken), .normal_taken(normal_taken));

  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic results;
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input vic_word_t exp, input vic_word_t got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input vic_addr_t a, input vic_word_t d, output vic_resp_t r);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge ref_clk);
      if (bvalid && !aw_p && !w_p)
      begin
        r = bresp;
        break;
      end
      if (aw_p && awready)
      begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready)
      begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input vic_addr_t a, output vic_word_t d, output vic_resp_t r);
    logic a_p;
    a_p = 1'b1;
    d = 32'hdead_beef;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge ref_clk);
      if (rvalid && !a_p)
      begin
        d = rdata;
        r = rresp;
        break;
      end
      if (a_p && arready)
      begin
        a_p = 1'b0;
        arvalid <= 1'b0;
      end
    end
  endtask

  task automatic wo(input vic_addr_t a, input vic_word_t d);
    wr(a, d, rs);
    chk("bresp", 32'(`VIC_RESP_OKAY), 32'(rs));
  endtask

  task automatic ro(input string n, input vic_addr_t a, input vic_word_t e);
    rd(a, rd_v, rs);
    chk(n, e, rd_v);
    chk("rresp", 32'(`VIC_RESP_OKAY), 32'(rs));
  endtask

  // Two edges from source to request; a third lets the sampled value show.
  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic reqs(input logic f, input logic n);
    chk("fast_request", 32'(f), 32'(fast_request));
    chk("normal_request", 32'(n), 32'(normal_request));
  endtask

  function automatic vic_word_t ent(input int i);
    return 32'h0001_0000 * (i + 1);
  endfunction

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    bad_count = 0;
    compares = 0;
    sys_rst <= 1'b1;
    ext_irq <= 16'h0000;
    chip_irq <= 48'h0000_0000_0000;
    {awvalid, wvalid, arvalid} <= 3'h0;
    {bready, rready} <= 2'h3;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hf;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    reqs(1'b0, 1'b0);
    ro("enable lo", `VIC_EN_LO, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
      wo(`VIC_ENTRY_BASE + 8'(4 * i), ent(i));
    ro("entry 7", `VIC_ENTRY_BASE + 8'h1c, ent(7));
    rd(8'h60, rd_v, rs);
    chk("unmapped rresp", 32'(`VIC_RESP_SLV), 32'(rs));
    chk("unmapped rdata", 32'h0000_0000, rd_v);
    wr(8'h21, 32'h0000_0000, rs);
    chk("misaligned bresp", 32'(`VIC_RESP_SLV), 32'(rs));
    ro("entry 0", `VIC_ENTRY_BASE, ent(0));
    ext_irq <= 16'h0001;
    settle();
    reqs(1'b0, 1'b0);
    ro("pending lo", `VIC_PEND_LO, 32'h0000_0001);
    wo(`VIC_EN_LO, 32'h0000_0001);
    for (int f = 0; f < 2; f++)
      for (int l = 0; l < 8; l++)
      begin
        wo(`VIC_FSEL_LO, 32'(f));
        wo(`VIC_PRIO_BASE, 32'(l));
        settle();
        reqs(f == 1, f == 0);
        if (f == 1)
          ro("fast vector", `VIC_FVEC, ent(l > 1 ? 1 : l));
        else
          ro("normal vector", `VIC_NVEC, ent(2 + (l > 5 ? 5 : l)));
      end
    wo(`VIC_FSEL_LO, 32'h0000_0000);
    wo(`VIC_EN_LO, 32'h0010_0009);
    wo(`VIC_PRIO_BASE, 32'h0000_3003);
    wo(`VIC_PRIO_BASE + 8'h08, 32'h0001_0000);
    ext_irq <= 16'h0009;
    chip_irq <= 48'h0000_0000_0010;
    settle();
    ro("ranked vector", `VIC_NVEC, ent(3) + 32'h0000_0050);
    wo(`VIC_PRIO_BASE + 8'h08, 32'h0003_0000);
    settle();
    ro("tied vector", `VIC_NVEC, ent(5));
    wo(`VIC_EN_LO, 32'h0010_0008);
    settle();
    ro("masked vector", `VIC_NVEC, ent(5) + 32'h0000_000c);
    ro("pending lo", `VIC_PEND_LO, 32'h0010_0009);
    ext_irq <= 16'h0000;
    chip_irq <= 48'h0000_0000_0000;
    wo(`VIC_PEND_LO, 32'hffff_ffff);
    settle();
    reqs(1'b0, 1'b0);
    ro("pending lo", `VIC_PEND_LO, 32'h0000_0000);
    ro("idle vector", `VIC_NVEC, 32'h0000_0000);
    wo(`VIC_EN_HI, 32'h8000_0000);
    chip_irq <= 48'h8000_0000_0000;
    settle();
    reqs(1'b0, 1'b1);
    ro("channel 63 vector", `VIC_NVEC, ent(2) + 32'h0000_00fc);
    chk("core fast entries", 32'h0000_0001, 32'(fast_taken));
    chk("core normal entries", 32'h0000_0003, 32'(normal_taken));
    results();
  end

  // The tests need well under 3000 cycles; this cuts a hang short.
  initial
  begin
    #(40 * 20000);
    bad_count++;
    results();
  end
endmodule

// [vic_core_model.sv]
// Model of the processor core side: it watches the two request levels.
// Assumes both requests are levels synchronous to ref_clk.
`timescale 1ns/100ps
module vic_core_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       fast_request,
  input  wire logic       normal_request,
  output logic      [7:0] fast_taken,
  output logic      [7:0] normal_taken
);
  // ---------------------------------------------------------------------------
  // Handler entries
  // ---------------------------------------------------------------------------
  logic       fast_q;
  logic       normal_q;
  logic [7:0] next_fast_taken;
  logic [7:0] next_normal_taken;

  // A level held high is one entry, so a stuck request is not counted twice.
  always_comb
  begin
    next_fast_taken   = fast_taken + 8'(fast_request & ~fast_q);
    next_normal_taken = normal_taken + 8'(normal_request & ~normal_q);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fast_q       <= 1'b0;
      normal_q     <= 1'b0;
      fast_taken   <= 8'h00;
      normal_taken <= 8'h00;
    end
    else
    begin
      fast_q       <= fast_request;
      normal_q     <= normal_request;
      fast_taken   <= next_fast_taken;
      normal_taken <= next_normal_taken;
    end
  end
endmodule

// [vic_params.svh]
// Constants for the vectored interrupt controller: offsets, field positions,
// reset values and counts. Included by the package, the design file and the bench.
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Channel and level counts
// ----------------------------------------------------------------------------
`define VIC_NCH        64
`define VIC_NEXT       16
`define VIC_FAST_LVLS  2
`define VIC_NORM_LVLS  6

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VIC_FSEL_LO    8'h00
`define VIC_FSEL_HI    8'h04
`define VIC_EN_LO      8'h08
`define VIC_EN_HI      8'h0C
`define VIC_PEND_LO    8'h10
`define VIC_PEND_HI    8'h14
`define VIC_FVEC       8'h18
`define VIC_NVEC       8'h1C
`define VIC_ENTRY_BASE 8'h20
`define VIC_PRIO_BASE  8'h40

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define VIC_PRIO_W     3
`define VIC_PRIO_STEP  4
`define VIC_PRIO_MASK  32'h7777_7777
`define VIC_RST_WORD   32'h0000_0000
`define VIC_RST_WIDE   64'h0000_0000_0000_0000
`define VIC_RESP_OKAY  2'h0
`define VIC_RESP_SLV   2'h2

`endif

// [vic_pkg.sv]
// Types shared by the vectored interrupt controller.
// Assumes vic_params.svh is on the include path.
`include "vic_params.svh"

package vic_pkg;
  typedef logic [7:0]  vic_addr_t;
  typedef logic [31:0] vic_word_t;
  typedef logic [3:0]  vic_strb_t;
  typedef logic [1:0]  vic_resp_t;
  typedef logic [2:0]  vic_lvl_t;
  typedef logic [5:0]  vic_ch_t;
  typedef logic [63:0] vic_vec64_t;
endpackage

// [vic_top.sv]
// Vectored interrupt controller with an AXI4-Lite register slave.
// Assumes sources are synchronous to ref_clk and a single-outstanding master.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "vic_params.svh"

module vic_top (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [15:0]      ext_irq,
  input  wire logic [47:0]      chip_irq,
  output logic                  fast_request,
  output logic                  normal_request,
  input  wire vic_pkg::vic_addr_t s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire vic_pkg::vic_word_t s_axi_wdata,
  input  wire vic_pkg::vic_strb_t s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output vic_pkg::vic_resp_t    s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire vic_pkg::vic_addr_t s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output vic_pkg::vic_word_t    s_axi_rdata,
  output vic_pkg::vic_resp_t    s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import vic_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  vic_vec64_t fsel, en, pend, next_fsel, next_en, next_pend, src, req_f, req_n;
  vic_word_t  entry [8];
  vic_word_t  prio [8];
  vic_word_t  next_entry [8];
  vic_word_t  next_prio [8];
  vic_word_t  fvec, nvec, next_fvec, next_nvec;
  logic       next_fast_request, next_normal_request;
  vic_lvl_t   lvl_f [64];
  vic_lvl_t   lvl_n [64];
  vic_lvl_t   fbest_lvl, nbest_lvl;
  vic_ch_t    fbest_ch, nbest_ch;
  logic       any_f, any_n;

  vic_addr_t  aw_addr, next_aw_addr;
  vic_word_t  w_data, next_w_data, next_rdata;
  vic_strb_t  w_strb, next_w_strb;
  logic       aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic       next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
  vic_resp_t  next_bresp, next_rresp;
  logic       wr_fire;

  // Sources are taken as levels; external lines occupy channels 0 to 15.
  assign src = {chip_irq, ext_irq};
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

  function automatic vic_word_t merge(vic_word_t old, vic_word_t d, vic_strb_t s);
    vic_word_t r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
      begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Per-channel routing and level
  // --------------------------------------------------------------------------
  // Out-of-range priority codes saturate at the highest level of each type (1 fast, 5 normal).
  for (genvar g = 0; g < `VIC_NCH; g++)
  begin : g_ch
    vic_lvl_t raw;
    assign raw      = vic_lvl_t'(prio[g / 8][`VIC_PRIO_STEP * (g % 8) +: `VIC_PRIO_W]);
    assign req_f[g] = pend[g] && en[g] && fsel[g];
    assign req_n[g] = pend[g] && en[g] && !fsel[g];
    assign lvl_f[g] = (raw > 3'h1) ? 3'h1 : raw;
    assign lvl_n[g] = (raw > 3'h5) ? 3'h5 : raw;
  end

  // --------------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------------
  // Lower level wins; among equals the lower channel wins by strict compare.
  always_comb
  begin
    any_f     = 1'b0;
    any_n     = 1'b0;
    fbest_lvl = 3'h7;
    nbest_lvl = 3'h7;
    fbest_ch  = 6'h0;
    nbest_ch  = 6'h0;
    for (int i = 0; i < `VIC_NCH; i++)
    begin
      if (req_f[i] && (!any_f || lvl_f[i] < fbest_lvl))
      begin
        any_f     = 1'b1;
        fbest_lvl = lvl_f[i];
        fbest_ch  = vic_ch_t'(i);
      end
      if (req_n[i] && (!any_n || lvl_n[i] < nbest_lvl))
      begin
        any_n     = 1'b1;
        nbest_lvl = lvl_n[i];
        nbest_ch  = vic_ch_t'(i);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Core registers: next values
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_fsel  = fsel;
    next_en    = en;
    next_entry = entry;
    next_prio  = prio;
    next_pend  = pend;
    if (wr_fire)
    begin
      unique case (aw_addr)
        `VIC_FSEL_LO: next_fsel[31:0]  = merge(fsel[31:0], w_data, w_strb);
        `VIC_FSEL_HI: next_fsel[63:32] = merge(fsel[63:32], w_data, w_strb);
        `VIC_EN_LO:   next_en[31:0]    = merge(en[31:0], w_data, w_strb);
        `VIC_EN_HI:   next_en[63:32]   = merge(en[63:32], w_data, w_strb);
        `VIC_PEND_LO: next_pend[31:0]  = pend[31:0] & ~merge(32'h0000_0000, w_data, w_strb);
        `VIC_PEND_HI: next_pend[63:32] = pend[63:32] & ~merge(32'h0000_0000, w_data, w_strb);
        default:
        begin
          if (aw_addr[7:5] == 3'h1 && aw_addr[1:0] == 2'h0)
          begin
            next_entry[aw_addr[4:2]] = merge(entry[aw_addr[4:2]], w_data, w_strb);
          end
          else if (aw_addr[7:5] == 3'h2 && aw_addr[1:0] == 2'h0)
          begin
            next_prio[aw_addr[4:2]] = merge(prio[aw_addr[4:2]], w_data, w_strb) & `VIC_PRIO_MASK;
          end
        end
      endcase
    end
    // A source that is high in the clearing cycle keeps its pending bit.
    next_pend = next_pend | src;
    next_fvec = any_f ? entry[fbest_lvl] + {24'h0000_00, fbest_ch, 2'h0} : `VIC_RST_WORD;
    next_nvec = any_n ? entry[3'h2 + nbest_lvl] + {24'h0000_00, nbest_ch, 2'h0} : `VIC_RST_WORD;
    next_fast_request   = any_f;
    next_normal_request = any_n;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fsel           <= `VIC_RST_WIDE;
      en             <= `VIC_RST_WIDE;
      pend           <= `VIC_RST_WIDE;
      entry          <= '{default: `VIC_RST_WORD};
      prio           <= '{default: `VIC_RST_WORD};
      fvec           <= `VIC_RST_WORD;
      nvec           <= `VIC_RST_WORD;
      fast_request   <= 1'b0;
      normal_request <= 1'b0;
    end
    else
    begin
      fsel           <= next_fsel;
      en             <= next_en;
      pend           <= next_pend;
      entry          <= next_entry;
      prio           <= next_prio;
      fvec           <= next_fvec;
      nvec           <= next_nvec;
      fast_request   <= next_fast_request;
      normal_request <= next_normal_request;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave: next values
  // --------------------------------------------------------------------------
  // Address and data are parked separately, so they may arrive in any order.
  always_comb
  begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr > 8'h5C || aw_addr[1:0] != 2'h0) ? `VIC_RESP_SLV : `VIC_RESP_OKAY;
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `VIC_RESP_OKAY;
      unique case (s_axi_araddr)
        `VIC_FSEL_LO: next_rdata = fsel[31:0];
        `VIC_FSEL_HI: next_rdata = fsel[63:32];
        `VIC_EN_LO:   next_rdata = en[31:0];
        `VIC_EN_HI:   next_rdata = en[63:32];
        `VIC_PEND_LO: next_rdata = pend[31:0];
        `VIC_PEND_HI: next_rdata = pend[63:32];
        `VIC_FVEC:    next_rdata = fvec;
        `VIC_NVEC:    next_rdata = nvec;
        default:
        begin
          next_rdata = `VIC_RST_WORD;
          if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > 8'h5C)
          begin
            next_rresp = `VIC_RESP_SLV;
          end
          else if (s_axi_araddr[7:5] == 3'h1)
          begin
            next_rdata = entry[s_axi_araddr[4:2]];
          end
          else
          begin
            next_rdata = prio[s_axi_araddr[4:2]];
          end
        end
      endcase
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready  = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      aw_hold       <= 1'b0;
      aw_addr       <= 8'h00;
      w_hold        <= 1'b0;
      w_data        <= `VIC_RST_WORD;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `VIC_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `VIC_RESP_OKAY;
      s_axi_rdata   <= `VIC_RST_WORD;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      aw_hold       <= next_aw_hold;
      aw_addr       <= next_aw_addr;
      w_hold        <= next_w_hold;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  pend_catch_a: assert property (src != 64'h0 |=> (pend & $past(src)) == $past(src))
    else $error("source level not captured as pending");
  mask_gate_a: assert property ((pend & en & fsel) == 64'h0 |=> !fast_request)
    else $error("fast request raised with no enabled fast channel");
  route_norm_a: assert property ((pend & en & ~fsel) != 64'h0 |=> normal_request)
    else $error("normal-routed channel did not raise normal request");
  fast_line_a: assert property (any_f && !any_n |=> fast_request && !normal_request)
    else $error("fast-only demand drove the wrong line");
  winner_rank_a: assert property (any_f |-> req_f[fbest_ch] && lvl_f[fbest_ch] == fbest_lvl)
    else $error("fast winner is not a ranked requester");
  level_range_a: assert property (any_n |-> nbest_lvl < 3'h6 && (!any_f || fbest_lvl < 3'h2))
    else $error("priority level outside its type range");
  entry_write_a: assert property (wr_fire && aw_addr == `VIC_ENTRY_BASE && w_strb == 4'hF
    |=> entry[0] == $past(w_data))
    else $error("entry table write lost");
  vector_out_a: assert property (any_n |=> nvec - {24'h0000_00, $past(nbest_ch), 2'h0}
    == $past(entry[3'h2 + nbest_lvl]))
    else $error("normal vector does not match entry of winner");
  hold_req_a: assert property (normal_request && (pend & en & ~fsel) != 64'h0 |=> normal_request)
    else $error("normal request dropped while demand remains");

  both_lines_c: cover property (fast_request && normal_request);
  fast_tie_c:   cover property ($countones(req_f) > 1);
  reg_write_c:  cover property (s_axi_bvalid && s_axi_bready);
endmodule
